/* File: hw/vic_consts.vh */
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH
// Source bit positions in the request/enable vectors
`define VIC_SRC_TICK 0
`define VIC_SRC_BOTH 1
`define VIC_SRC_EDGE1 2
`define VIC_SRC_EDGE2 3
`define VIC_SRC_SER 4
`define VIC_SRC_CMP 5
`define VIC_SRC_TEST 6
`define VIC_SRC_WATCH 7
`define VIC_NSRC 8
// Vector table addresses
`define VIC_VEC_TICK 14'h0002
`define VIC_VEC_EDGE1 14'h0004
`define VIC_VEC_EDGE2 14'h0006
`define VIC_VEC_SER 14'h0008
`define VIC_VEC_CMP 14'h000A
// Reset values
`define VIC_RST_FLAGS 8'h00
`define VIC_RST_MODE 2'h0
// Edge mode codes
`define VIC_MODE_RISE 2'h0
`define VIC_MODE_FALL 2'h1
`define VIC_MODE_BOTH 2'h2
`define VIC_MODE_OFF 2'h3
`endif

/* File: hw/vic_ctrl.v */
`timescale 1ns/10ps
`include "vic_consts.vh"
// Notes on behaviour
// - six vectored sources, nesting allowed by software
// - edge pin one selectable, edge two vectors
// - serial done and count match vector
// - count match raises its own compare request
// - both-edge pin requests on every edge
// - interval timer tick raises request
// - simultaneous requests taken in fixed priority
// - test sources flag only, never vector
// - test flag from pin rise or key fall
// - watch tick sets watch request flag
// - vector needs source and master enable
// - request flags readable by software
// - enabled request releases standby
// - vector address points into program table
// - reset clears flags, enables, modes
// - edge one and edge two each clocked through its own synchroniser
module vic_ctrl
#(
  parameter NKEY = 8
)
(
  input wire clk,
  input wire srst,
  input wire interval_tick_source,
  input wire both_edge_pin_source,
  input wire first_edge_pin,
  input wire second_edge_pin_source,
  input wire serial_done_source,
  input wire count_match_source,
  input wire rising_test_input,
  input wire [NKEY-1:0] key_return_inputs,
  input wire watch_tick_test_source,
  input wire master_irq_enable_wr,
  input wire master_irq_enable_in,
  input wire enable_wr,
  input wire [7:0] source_enable_in,
  input wire request_wr,
  input wire [7:0] request_in,
  input wire mode_wr,
  input wire [5:0] external_edge_mode_in,
  input wire vector_ack,
  output reg [7:0] source_request_flag,
  output reg [7:0] source_enable_flag,
  output reg master_irq_enable,
  output reg [5:0] external_edge_mode_regs,
  output reg vector_pending,
  output reg [13:0] vector_address,
  output reg [2:0] vector_source,
  output reg standby_release
);
  wire both_rise;
  wire both_fall;
  wire e1_rise;
  wire e1_fall;
  wire e2_rise;
  wire e2_fall;
  wire t_rise;
  wire [NKEY-1:0] k_fall;
  reg [7:0] set_d;
  reg [7:0] clr_d;
  reg [7:0] req_d;
  reg [5:0] vreq;
  reg [2:0] win_d;
  reg [13:0] addr_d;
  reg any_d;
  reg ack_q;

  // Selected-edge match for a two-bit mode field
  function edge_hit;
    input [1:0] mode;
    input r;
    input f;
    begin
      case (mode)
        `VIC_MODE_RISE: edge_hit = r;
        `VIC_MODE_FALL: edge_hit = f;
        `VIC_MODE_BOTH: edge_hit = r | f;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  vic_edge_det u_both
  (
    .clk(clk),
    .srst(srst),
    .pin(both_edge_pin_source),
    .rise(both_rise),
    .fall(both_fall)
  );

  vic_edge_det u_e1
  (
    .clk(clk),
    .srst(srst),
    .pin(first_edge_pin),
    .rise(e1_rise),
    .fall(e1_fall)
  );

  // Edge two is asynchronous on silicon; here synchronised instead
  vic_edge_det u_e2
  (
    .clk(clk),
    .srst(srst),
    .pin(second_edge_pin_source),
    .rise(e2_rise),
    .fall(e2_fall)
  );

  vic_edge_det u_test
  (
    .clk(clk),
    .srst(srst),
    .pin(rising_test_input),
    .rise(t_rise),
    .fall()
  );

  genvar gi;
  generate
    for (gi = 0; gi < NKEY; gi = gi + 1)
    begin : g_key
      vic_edge_det u_key
      (
        .clk(clk),
        .srst(srst),
        .pin(key_return_inputs[gi]),
        .rise(),
        .fall(k_fall[gi])
      );
    end
  endgenerate

  // Flag set terms; internal sources are same-clock pulses
  always @*
  begin
    set_d = 8'h00;
    set_d[`VIC_SRC_TICK] = interval_tick_source;
    set_d[`VIC_SRC_BOTH] = both_rise | both_fall;
    set_d[`VIC_SRC_EDGE1] = edge_hit(external_edge_mode_regs[1:0],
                                     e1_rise, e1_fall);
    set_d[`VIC_SRC_EDGE2] = edge_hit(external_edge_mode_regs[3:2],
                                     e2_rise, e2_fall);
    set_d[`VIC_SRC_SER] = serial_done_source;
    set_d[`VIC_SRC_CMP] = count_match_source;
    set_d[`VIC_SRC_TEST] = edge_hit(external_edge_mode_regs[5:4],
                                    t_rise, 1'b0) | (|k_fall);
    set_d[`VIC_SRC_WATCH] = watch_tick_test_source;
  end

  always @*
  begin
    vreq = source_request_flag[5:0] & source_enable_flag[5:0]
           & {6{master_irq_enable}};
    any_d = |vreq;
    win_d = 3'd0;
    addr_d = `VIC_VEC_TICK;
    if (vreq[`VIC_SRC_TICK] | vreq[`VIC_SRC_BOTH])
    begin
      win_d = vreq[`VIC_SRC_TICK] ? 3'd0 : 3'd1;
      addr_d = `VIC_VEC_TICK;
    end
    else if (vreq[`VIC_SRC_EDGE1])
    begin
      win_d = 3'd2;
      addr_d = `VIC_VEC_EDGE1;
    end
    else if (vreq[`VIC_SRC_EDGE2])
    begin
      win_d = 3'd3;
      addr_d = `VIC_VEC_EDGE2;
    end
    else if (vreq[`VIC_SRC_SER])
    begin
      win_d = 3'd4;
      addr_d = `VIC_VEC_SER;
    end
    else if (vreq[`VIC_SRC_CMP])
    begin
      win_d = 3'd5;
      addr_d = `VIC_VEC_CMP;
    end
  end

  always @*
  begin
    clr_d = 8'h00;
    if (vector_ack && vector_pending)
      clr_d[vector_source] = 1'b1;
    req_d = source_request_flag;
    if (request_wr)
      req_d = request_in;
    req_d = (req_d & ~clr_d) | set_d;
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      source_request_flag <= `VIC_RST_FLAGS;
      source_enable_flag <= `VIC_RST_FLAGS;
      master_irq_enable <= 1'b0;
      external_edge_mode_regs <= {3{`VIC_RST_MODE}};
      vector_pending <= 1'b0;
      vector_address <= `VIC_VEC_TICK;
      vector_source <= 3'd0;
      standby_release <= 1'b0;
      ack_q <= 1'b0;
    end
    else
    begin
      source_request_flag <= req_d;
      if (enable_wr)
        source_enable_flag <= source_enable_in;
      if (master_irq_enable_wr)
        master_irq_enable <= master_irq_enable_in;
      if (mode_wr)
        external_edge_mode_regs <= external_edge_mode_in;
      ack_q <= vector_ack;
      // test sources excluded from vectoring
      // Ack gap stops a stale vector after clear
      vector_pending <= any_d & ~vector_ack & ~ack_q;
      vector_address <= addr_d;
      vector_source <= win_d;
      standby_release <= |(source_request_flag & source_enable_flag);
    end
  end
endmodule

/* File: hw/vic_edge_det.v */
`timescale 1ns/10ps
// Two-flop synchroniser plus rise/fall detector for one pin
module vic_edge_det
(
  input wire clk,
  input wire srst,
  input wire pin,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;
  reg last_q;

  // First flop feeds only the second
  always @(posedge clk)
  begin
    if (srst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  bit clk, srst = 1, rising_test_input, watch_tick_test_source, slow;
  bit master_irq_enable_wr, master_irq_enable_in, enable_wr, request_wr;
  bit mode_wr;
  bit [7:0] key_return_inputs = 8'hFF, source_enable_in, request_in;
  bit [5:0] external_edge_mode_in, ev, pin;
  wire interval_tick_source = ev[0];
  wire serial_done_source = ev[4];
  wire count_match_source = ev[5];
  wire both_edge_pin_source = pin[1];
  wire first_edge_pin = pin[2];
  wire second_edge_pin_source = pin[3];
  logic vector_ack, master_irq_enable, vector_pending, standby_release;
  logic [7:0] source_request_flag, source_enable_flag;
  logic [5:0] external_edge_mode_regs;
  logic [13:0] vector_address, got_addr;
  logic [2:0] vector_source;
  int num_errors, samples_checked, cyc;
  vic_ctrl u_dut (.*);
  vic_cpu_model u_cpu (.*);
  // 100 ns period
  always #50 clk = ~clk;
  // Ceiling in case a vector never comes
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      wrap_up;
    end
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Enables and master; c also clears every flag
  task cfg(input bit [7:0] e, input bit m, input bit c);
    @(negedge clk);
    {enable_wr, master_irq_enable_wr, request_wr} = {2'h3, c};
    {source_enable_in, master_irq_enable_in} = {e, m};
    @(negedge clk);
    {enable_wr, master_irq_enable_wr, request_wr} = '0;
  endtask
  // Pins toggle, internal sources pulse one cycle
  task fire(input int s);
    @(negedge clk);
    pin[s] = (s > 0 && s < 4) ? ~pin[s] : pin[s];
    ev[s] = !(s > 0 && s < 4);
    @(negedge clk);
    ev = '0;
  endtask
  // Skip an edge first so a stale acknowledge is not seen twice
  task take(input logic [13:0] a, input logic [7:0] f);
    @(negedge clk);
    for (int i = 0; i < 20 && vector_ack !== 1'b1; i++)
      @(negedge clk);
    chk("addr", got_addr, a);
    chk("left", source_request_flag, f);
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    srst = 0;
    chk("rst", {source_request_flag, source_enable_flag}, '0);
    chk("rst2", {master_irq_enable, external_edge_mode_regs}, '0);
    // Each source alone; last round is a falling edge, slow answer
    cfg(8'hFF, 1, 1);
    for (int s = 0; s < 7; s++)
    begin
      slow = s == 6;
      fire(s == 6 ? 1 : s);
      take(s < 2 || s == 6 ? 14'h0002 : 14'(2 * s), '0);
    end
    // Three at once with master off, then in fixed order
    cfg(8'hFF, 0, 0);
    ev = 6'h31;
    @(negedge clk);
    ev = '0;
    repeat (2) @(negedge clk);
    chk("held", source_request_flag, 8'h31);
    chk("idle", vector_pending, '0);
    chk("wake", standby_release, 1'b1);
    cfg(8'hFF, 1, 0);
    take(14'h0002, 8'h30);
    take(14'h0008, 8'h20);
    take(14'h000A, 8'h00);
    // Test sources flag and wake, never vector
    cfg(8'hC0, 1, 1);
    key_return_inputs = 8'hF7;
    watch_tick_test_source = 1;
    @(negedge clk);
    watch_tick_test_source = 0;
    repeat (5) @(negedge clk);
    chk("test", source_request_flag, 8'hC0);
    chk("novec", vector_pending, '0);
    chk("wake2", standby_release, 1'b1);
    // Disabled source flags but must not wake
    cfg(8'h00, 1, 1);
    rising_test_input = 1;
    repeat (5) @(negedge clk);
    chk("pin", source_request_flag, 8'h40);
    chk("sleep", standby_release, '0);
    // Falling mode on edge one, edge two switched off
    cfg(8'h0C, 1, 1);
    @(negedge clk);
    mode_wr = 1;
    external_edge_mode_in = 6'h1D;
    rising_test_input = 0;
    @(negedge clk);
    mode_wr = 0;
    chk("mode", external_edge_mode_regs, 6'h1D);
    fire(3);
    fire(2);
    // Off pin must leave no flag behind the taken one
    take(14'h0004, '0);
    // Mid-run reset over two edges, state must clear
    @(negedge clk);
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    chk("rst3", {source_request_flag, source_enable_flag}, '0);
    chk("rst4", {master_irq_enable, external_edge_mode_regs}, '0);
    wrap_up;
  end
endmodule

/* File: tb/vic_checker.sv */
`timescale 1ns/10ps
// Watches flags, vectors and wake of the controller
module vic_checker (
  input clk,
  input srst,
  input serial_done_source,
  input watch_tick_test_source,
  input vector_ack,
  input [7:0] source_request_flag,
  input [7:0] source_enable_flag,
  input master_irq_enable,
  input vector_pending,
  input [13:0] vector_address,
  input [2:0] vector_source,
  input standby_release
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // Enabled requests; only these may wake or vector
  wire [7:0] live = source_request_flag & source_enable_flag;
  // Pending drops while the taken flag clears
  sequence s_quiet;
    !vector_pending [*2];
  endsequence
  AST_RST: assert property (disable iff (1'b0) srst |=>
    {source_request_flag, source_enable_flag, master_irq_enable} == '0)
    else $error("reset");
  AST_SER: assert property (serial_done_source |=>
    source_request_flag[4]) else $error("serial");
  AST_WATCH: assert property (watch_tick_test_source |=>
    source_request_flag[7]) else $error("watch");
  AST_TEST: assert property (vector_pending |->
    vector_source < 3'h6) else $error("test");
  AST_ADDR: assert property (vector_pending |->
    vector_address == (vector_source < 3'h2 ? 14'h0002 :
    {10'h000, vector_source, 1'b0})) else $error("address");
  AST_PRI: assert property ($rose(vector_pending) |->
    ($past(live) & ((8'h01 << vector_source) - 8'h01)) == '0)
    else $error("priority");
  AST_ACK: assert property (vector_ack && vector_pending |=>
    s_quiet) else $error("ack");
  AST_WAKE: assert property (standby_release ==
    $past(|live)) else $error("wake");
  AST_NOVEC: assert property (live[5:0] == 6'h00 |=>
    !vector_pending) else $error("novec");
  AST_MASTER: assert property (!master_irq_enable |=>
    !vector_pending) else $error("master");
endmodule
bind vic_ctrl vic_checker u_chk (.*);

/* File: tb/vic_cpu_model.sv */
`timescale 1ns/10ps
// CPU side: takes a vector at once or after four idle cycles
module vic_cpu_model (
  input clk,
  input srst,
  input slow,
  input vector_pending,
  input [13:0] vector_address,
  output logic vector_ack = '0,
  output logic [13:0] got_addr
);
  int wait_q = 0;
  always @(negedge clk)
  begin
    vector_ack <= '0;
    wait_q <= vector_pending && !vector_ack ? wait_q + 1 : 0;
    if (!srst && vector_pending && !vector_ack && wait_q >= 4 * slow)
    begin
      vector_ack <= '1;
      got_addr <= vector_address;
    end
  end
endmodule
